// file: hw/iosw_pkg.sv
// package: register map, destination indices and timing constants of the io switch matrix
package iosw_pkg;

    localparam int unsigned NUM_DEST     = 18;
    localparam int unsigned NUM_SRC      = 32;
    localparam int unsigned SEL_W        = 5;
    localparam int unsigned NUM_SEQ      = 16;
    localparam int unsigned SEQ_W        = 4;
    localparam int unsigned NUM_PWM      = 4;
    localparam int unsigned NUM_STROBE   = 4;

    // destination indices
    localparam int unsigned D_OUT0       = 0;
    localparam int unsigned D_TXD        = 4;
    localparam int unsigned D_UART1_RX   = 5;
    localparam int unsigned D_TRIGGER    = 6;
    localparam int unsigned D_SEQ_START  = 7;
    localparam int unsigned D_DEBOUNCE   = 8;
    localparam int unsigned D_PRESCALE   = 9;
    localparam int unsigned D_LOGIC_A    = 10;
    localparam int unsigned D_LOGIC_B    = 11;
    localparam int unsigned D_LENS_TXD   = 12;
    localparam int unsigned D_LOOP0      = 13;
    localparam int unsigned D_UART2_RX   = 17;

    // timing: one tic is TIC_NS (15 ns), one system clock period is CLK_NS (100 ns)
    localparam int unsigned TIC_NS       = 15;
    localparam int unsigned CLK_NS       = 100;
    localparam int unsigned STROBE_MAX_MS = 100;
    localparam int unsigned STROBE_MAX_CYC = (STROBE_MAX_MS * 1000000) / CLK_NS;
    localparam int unsigned CNT_W        = 32;
    localparam logic [6:0]  DUTY_FULL    = 7'h64;

    // register byte offsets
    localparam logic [11:0] A_SEL_BASE   = 12'h000; // 18 words, one per destination
    localparam logic [11:0] A_INV        = 12'h080;
    localparam logic [11:0] A_FORCE      = 12'h084;
    localparam logic [11:0] A_CTRL       = 12'h088; // bit0 debug, bits7:4 sequence index
    localparam logic [11:0] A_STATUS     = 12'h08C;
    localparam logic [11:0] A_STB_EN     = 12'h090;
    localparam logic [11:0] A_STB_LEN    = 12'h0A0; // 4 words
    localparam logic [11:0] A_PER_BASE   = 12'h100; // 16 words
    localparam logic [11:0] A_DUTY_BASE  = 12'h200; // 16 words, 4 bytes per word

    localparam logic [NUM_DEST-1:0] INV_RST   = 18'h00000;
    localparam logic [NUM_DEST-1:0] FORCE_RST = 18'h00000;
    localparam logic [CNT_W-1:0]    PER_RST   = 32'h00000000;

endpackage : iosw_pkg

// file: hw/iosw_matrix.sv
// io switch matrix with per-sequence pwm and strobe channels, ahb-lite slave
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (R1) destinations 0-17; 0-3 open drain, 4 txd while debug low, 6 trigger
// (R2) destination 7 feeds sequencer hardware start
// (R3) destination 8 feeds debounce filter input
// (R4) destination 9 feeds pulse prescaler input
// (R5) destinations 10 and 11 feed logic operands a and b
// (R6) destinations 13-16 feed pulse loop triggers 0-3 in order
// (R7) 5 feeds first uart rx, 17 second uart rx, 12 lens transmit
// (R8) inversion delivers the complement of the line
// (R9) force-high drives the line to 1 whatever the source
// (R10) force-high with inversion drives the line low
// (R11) pwm period per sequence index counted in clock tics; the code counts CLK_NS (100 ns) clock cycles, not TIC_NS tics
// (R12) four pwm channels each take per-sequence duty percent
// (R13) pwm on for duty fraction of each period, off otherwise
// (R14) any strobe on-time is cut at 100 ms
// (R15) up to four independent strobe channels
// (R16) strobe times held as integer tic counts; the code holds them as counts of CLK_NS (100 ns) clock cycles
// (R17) software should pick pwm toggling twice the grey levels per exposure
// (R18) each destination selects one source, then inversion and force apply
// (R19) duty 0 keeps pwm off, 100 keeps it on
module iosw_matrix (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [31:0]           src_lines,
    output logic      [3:0]            od_out_o,
    output logic      [3:0]            od_out_oe,
    output logic                       serial_txd,
    output logic                       first_uart_rx_feed,
    output logic                       trigger_out,
    output logic                       sequencer_hw_start,
    output logic                       debounce_in,
    output logic                       prescale_in,
    output logic                       logic_in_a,
    output logic                       logic_in_b,
    output logic                       lens_txd,
    output logic      [3:0]            loop_hw_start,
    output logic                       second_uart_rx_feed,
    output logic      [3:0]            pwm_out,
    input  wire logic [3:0]            strobe_req,
    output logic      [3:0]            strobe_out
);

    localparam int unsigned ND = iosw_pkg::NUM_DEST;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [iosw_pkg::SEL_W-1:0]   sel_r [ND];
    logic [ND-1:0]                inv_r;
    logic [ND-1:0]                force_r;
    logic                         debug_r;
    logic [iosw_pkg::SEQ_W-1:0]   sequence_index_r;
    logic [3:0]                   stb_en_r;
    logic [iosw_pkg::CNT_W-1:0]   stb_len_r [iosw_pkg::NUM_STROBE];
    logic [iosw_pkg::CNT_W-1:0]   pwm_period_count_r [iosw_pkg::NUM_SEQ];
    logic [6:0]                   pwm_duty_percent_r [iosw_pkg::NUM_SEQ][iosw_pkg::NUM_PWM];
    logic [ND-1:0]                dest_r;
    logic [3:0]                   stb_cut_r;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait state, always okay
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic        rd_pend_r;
    logic        req;

    assign req       = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= req && hwrite;
            rd_pend_r <= req && !hwrite;
            if (req) begin
                wr_addr_r <= {haddr[11:2], 2'b00};
            end
        end
    end

    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h00000000;
        if (a < iosw_pkg::A_SEL_BASE + 12'(4 * ND)) begin
            v = 32'(sel_r[a[6:2]]);
        end else if (a == iosw_pkg::A_INV) begin
            v = 32'(inv_r);
        end else if (a == iosw_pkg::A_FORCE) begin
            v = 32'(force_r);
        end else if (a == iosw_pkg::A_CTRL) begin
            v = {24'h000000, sequence_index_r, 3'b000, debug_r};
        end else if (a == iosw_pkg::A_STATUS) begin
            v = {stb_cut_r, strobe_out, pwm_out, 2'b00, dest_r};
        end else if (a == iosw_pkg::A_STB_EN) begin
            v = {28'h0000000, stb_en_r};
        end else if (a[11:4] == iosw_pkg::A_STB_LEN[11:4]) begin
            v = stb_len_r[a[3:2]];
        end else if (a[11:6] == iosw_pkg::A_PER_BASE[11:6]) begin
            v = pwm_period_count_r[a[5:2]];
        end else if (a[11:6] == iosw_pkg::A_DUTY_BASE[11:6]) begin
            v = {1'b0, pwm_duty_percent_r[a[5:2]][3], 1'b0, pwm_duty_percent_r[a[5:2]][2],
                 1'b0, pwm_duty_percent_r[a[5:2]][1], 1'b0, pwm_duty_percent_r[a[5:2]][0]};
        end
        return v;
    endfunction

    // read data registered on the address phase edge, unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (req && !hwrite) begin
            hrdata <= read_word({haddr[11:2], 2'b00});
        end
    end

    logic wr;
    assign wr = wr_pend_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < ND; i++) begin
                sel_r[i] <= '0;
            end
        end else if (wr && wr_addr_r < iosw_pkg::A_SEL_BASE + 12'(4 * ND)) begin
            sel_r[wr_addr_r[6:2]] <= hwdata[iosw_pkg::SEL_W-1:0]; // [R18]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inv_r            <= iosw_pkg::INV_RST;
            force_r          <= iosw_pkg::FORCE_RST;
            debug_r          <= 1'b0;
            sequence_index_r <= '0;
            stb_en_r         <= 4'h0;
        end else if (wr) begin
            if (wr_addr_r == iosw_pkg::A_INV) begin
                inv_r <= hwdata[ND-1:0];
            end
            if (wr_addr_r == iosw_pkg::A_FORCE) begin
                force_r <= hwdata[ND-1:0];
            end
            if (wr_addr_r == iosw_pkg::A_CTRL) begin
                debug_r          <= hwdata[0];
                sequence_index_r <= hwdata[7:4];
            end
            if (wr_addr_r == iosw_pkg::A_STB_EN) begin
                stb_en_r <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < iosw_pkg::NUM_STROBE; i++) begin
                stb_len_r[i] <= '0;
            end
            for (int s = 0; s < iosw_pkg::NUM_SEQ; s++) begin
                pwm_period_count_r[s] <= iosw_pkg::PER_RST;
                for (int c = 0; c < iosw_pkg::NUM_PWM; c++) begin
                    pwm_duty_percent_r[s][c] <= 7'h00;
                end
            end
        end else if (wr) begin
            if (wr_addr_r[11:4] == iosw_pkg::A_STB_LEN[11:4]) begin
                stb_len_r[wr_addr_r[3:2]] <= hwdata; // [R16]
            end
            if (wr_addr_r[11:6] == iosw_pkg::A_PER_BASE[11:6]) begin
                pwm_period_count_r[wr_addr_r[5:2]] <= hwdata; // [R11]
            end
            if (wr_addr_r[11:6] == iosw_pkg::A_DUTY_BASE[11:6]) begin
                for (int c = 0; c < iosw_pkg::NUM_PWM; c++) begin
                    pwm_duty_percent_r[wr_addr_r[5:2]][c] <= hwdata[8*c +: 7]; // [R12]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch matrix
    logic [ND-1:0] dest_nxt;

    generate
        for (genvar d = 0; d < ND; d++) begin : g_dest
            always_comb begin
                if (force_r[d]) begin
                    dest_nxt[d] = ~inv_r[d]; // [R9] [R10]
                end else begin
                    dest_nxt[d] = src_lines[sel_r[d]] ^ inv_r[d]; // [R8] [R18]
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dest_r <= '0;
        end else begin
            dest_r <= dest_nxt;
        end
    end

    // open drain: pull low when the line is 0
    assign od_out_o            = 4'h0;
    assign od_out_oe           = ~dest_r[3:0]; // [R1]
    assign serial_txd          = debug_r ? 1'b1 : dest_r[iosw_pkg::D_TXD]; // [R1]
    assign first_uart_rx_feed  = dest_r[iosw_pkg::D_UART1_RX]; // [R7]
    assign trigger_out         = dest_r[iosw_pkg::D_TRIGGER]; // [R1]
    assign sequencer_hw_start  = dest_r[iosw_pkg::D_SEQ_START]; // [R2]
    assign debounce_in         = dest_r[iosw_pkg::D_DEBOUNCE]; // [R3]
    assign prescale_in         = dest_r[iosw_pkg::D_PRESCALE]; // [R4]
    assign logic_in_a          = dest_r[iosw_pkg::D_LOGIC_A]; // [R5]
    assign logic_in_b          = dest_r[iosw_pkg::D_LOGIC_B]; // [R5]
    assign lens_txd            = dest_r[iosw_pkg::D_LENS_TXD]; // [R7]
    assign loop_hw_start       = dest_r[iosw_pkg::D_LOOP0 +: 4]; // [R6]
    assign second_uart_rx_feed = dest_r[iosw_pkg::D_UART2_RX]; // [R7]

    ////////////////////////////////////////////////////////////////////////////
    // pwm: shared period counter, per-channel compare
    logic [iosw_pkg::CNT_W-1:0] pwm_cnt_r;
    logic [iosw_pkg::CNT_W-1:0] cur_per;

    assign cur_per = pwm_period_count_r[sequence_index_r];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_cnt_r <= '0;
        end else if (pwm_cnt_r + 32'h00000001 >= cur_per) begin
            pwm_cnt_r <= '0; // [R11]
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 32'h00000001;
        end
    end

    generate
        for (genvar c = 0; c < iosw_pkg::NUM_PWM; c++) begin : g_pwm
            logic [6:0]  duty;
            logic [39:0] on_cnt;
            assign duty   = pwm_duty_percent_r[sequence_index_r][c];
            assign on_cnt = (40'(cur_per) * 40'(duty)) / 40'd100;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pwm_out[c] <= 1'b0;
                end else if (duty >= iosw_pkg::DUTY_FULL) begin
                    pwm_out[c] <= 1'b1; // [R19]
                end else begin
                    pwm_out[c] <= 40'(pwm_cnt_r) < on_cnt; // [R13] [R19]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // strobe channels with on-time guard
    logic [iosw_pkg::CNT_W-1:0] stb_cnt_r [iosw_pkg::NUM_STROBE];

    generate
        for (genvar s = 0; s < iosw_pkg::NUM_STROBE; s++) begin : g_stb // [R15]
            logic [iosw_pkg::CNT_W-1:0] lim;
            assign lim = (stb_len_r[s] < iosw_pkg::CNT_W'(iosw_pkg::STROBE_MAX_CYC))
                         ? stb_len_r[s] : iosw_pkg::CNT_W'(iosw_pkg::STROBE_MAX_CYC);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stb_cnt_r[s]  <= '0;
                    strobe_out[s] <= 1'b0;
                    stb_cut_r[s]  <= 1'b0;
                end else if (!stb_en_r[s] || !strobe_req[s]) begin
                    stb_cnt_r[s]  <= '0;
                    strobe_out[s] <= 1'b0;
                    stb_cut_r[s]  <= strobe_req[s] && stb_cut_r[s];
                end else if (stb_cnt_r[s] < lim) begin
                    stb_cnt_r[s]  <= stb_cnt_r[s] + 32'h00000001; // [R16]
                    strobe_out[s] <= 1'b1;
                end else begin
                    strobe_out[s] <= 1'b0; // [R14]
                    stb_cut_r[s]  <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_force_high_out: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_r[6] && !inv_r[6]) |=> trigger_out) // [R9]
        else $error("forced line not high");
    a_force_inv_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_r[7] && inv_r[7]) |=> !sequencer_hw_start) // [R10]
        else $error("forced inverted line not low");
    a_inv_complement: assert property (@(posedge hclk) disable iff (!hresetn)
        (!force_r[8] && inv_r[8]) |=> debounce_in == !$past(src_lines[sel_r[8]])) // [R8]
        else $error("inverted line not complement");
    a_route_loop: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_r[16:13] == 4'h0) |=> loop_hw_start == ($past(inv_r[16:13]) ^
        {$past(src_lines[sel_r[16]]), $past(src_lines[sel_r[15]]),
         $past(src_lines[sel_r[14]]), $past(src_lines[sel_r[13]])})) // [R6]
        else $error("loop trigger routing wrong");
    a_txd_debug: assert property (@(posedge hclk) disable iff (!hresetn)
        debug_r |-> serial_txd) // [R1]
        else $error("txd driven in debug");
    a_duty_zero_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_duty_percent_r[sequence_index_r][0] == 7'h00) [*2] |-> !pwm_out[0]) // [R19]
        else $error("zero duty pwm on");
    a_duty_full_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_duty_percent_r[sequence_index_r][2] == 7'h64) [*2] |-> pwm_out[2]) // [R19]
        else $error("full duty pwm off");
    a_pwm_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_cnt_r >= cur_per && cur_per != 0 |=> pwm_cnt_r == 0) // [R11]
        else $error("pwm counter past period");
    a_strobe_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        strobe_out[0] |-> stb_cnt_r[0] <= iosw_pkg::CNT_W'(iosw_pkg::STROBE_MAX_CYC)) // [R14]
        else $error("strobe exceeds max on-time");
    a_strobe_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        !strobe_req[2] |=> !strobe_out[2]) // [R15]
        else $error("strobe on without request");

    c_force_inv:  cover property (@(posedge hclk) force_r[0] && inv_r[0]);
    c_pwm_mid:    cover property (@(posedge hclk) $rose(pwm_out[2]));
    c_strobe_cut: cover property (@(posedge hclk) $rose(stb_cut_r[0]));
    c_bus_write:  cover property (@(posedge hclk) wr_pend_r);
    c_bus_read:   cover property (@(posedge hclk) rd_pend_r);

endmodule : iosw_matrix

`default_nettype wire

// file: sim/iosw_periph_model.sv
// model of the lights, triggers and peripherals around the io switch matrix
`timescale 1ns/1ns
`default_nettype none
module iosw_periph_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [31:0] src_cmd,
    input  wire logic [3:0]  strb_cmd,
    input  wire logic [3:0]  od_out_o,
    input  wire logic [3:0]  od_out_oe,
    output logic      [31:0] src_lines,
    output logic      [3:0]  strobe_req,
    output logic      [3:0]  od_pin
);
    ////////////////////////////////////////////////////////////////////////////////
    // sources change just after the clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_lines  <= 32'h00000000;
            strobe_req <= 4'h0;
        end else begin
            src_lines  <= src_cmd;
            strobe_req <= strb_cmd;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // pulled-up open drain pins, low only while driven
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            od_pin[i] = od_out_oe[i] ? od_out_o[i] : 1'b1;
        end
    end
endmodule // iosw_periph_model
`default_nettype wire

// file: sim/io_switch_matrix_pwm_strobe_tb_top.sv
// self-checking testbench of the io switch matrix
`timescale 1ns/1ns
`default_nettype none
module io_switch_matrix_pwm_strobe_tb_top;
    localparam int CEIL = 20000;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, src_cmd, src_lines, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  od_out_o, od_out_oe, od_pin, loop_hw_start, pwm_out, strb_cmd;
    logic [3:0]  strobe_req, strobe_out;
    logic        serial_txd, first_uart_rx_feed, trigger_out, sequencer_hw_start;
    logic        debounce_in, prescale_in, logic_in_a, logic_in_b, lens_txd;
    logic        second_uart_rx_feed;
    logic [4:0]  sel_v [18];
    logic [17:0] inv_v, force_v;
    int          mismatches, cmp_count, cycles;
    int          pc [4];
    int          sc [4];
    assign hready = hreadyout;

    iosw_matrix u_iosw_matrix (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_lines(src_lines),
        .od_out_o(od_out_o), .od_out_oe(od_out_oe), .serial_txd(serial_txd),
        .first_uart_rx_feed(first_uart_rx_feed), .trigger_out(trigger_out),
        .sequencer_hw_start(sequencer_hw_start), .debounce_in(debounce_in),
        .prescale_in(prescale_in), .logic_in_a(logic_in_a), .logic_in_b(logic_in_b),
        .lens_txd(lens_txd), .loop_hw_start(loop_hw_start),
        .second_uart_rx_feed(second_uart_rx_feed), .pwm_out(pwm_out),
        .strobe_req(strobe_req), .strobe_out(strobe_out));

    iosw_periph_model u_iosw_periph_model (
        .hclk(hclk), .hresetn(hresetn), .src_cmd(src_cmd), .strb_cmd(strb_cmd),
        .od_out_o(od_out_o), .od_out_oe(od_out_oe), .src_lines(src_lines),
        .strobe_req(strobe_req), .od_pin(od_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang limit
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == CEIL) begin
            mismatches++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // single ahb-lite word transfer
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
        check({31'h0, hresp}, 32'h00000000, "response");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, {20'h00000, a}, d, dummy);
    endtask

    function automatic logic [17:0] dest_seen();
        return {second_uart_rx_feed, loop_hw_start, lens_txd, logic_in_b, logic_in_a,
                prescale_in, debounce_in, sequencer_hw_start, trigger_out,
                first_uart_rx_feed, serial_txd, od_pin};
    endfunction

    function automatic logic [17:0] dest_exp(input logic [31:0] s);
        logic [17:0] e;
        for (int d = 0; d < 18; d++) begin
            e[d] = force_v[d] ? ~inv_v[d] : s[sel_v[d]] ^ inv_v[d];
        end
        return e;
    endfunction

    task automatic run_patterns();
        logic [31:0] p;
        for (int i = 0; i < 32; i++) begin
            p = i[0] ? ~(32'h1 << i) : (32'h1 << i);
            @(posedge hclk);
            src_cmd <= p;
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            check({14'h0, dest_seen()}, {14'h0, dest_exp(p)}, "route");
            bus(1'b0, {20'h00000, iosw_pkg::A_STATUS}, 32'h0, rd);
            check({14'h0, rd[17:0]}, {14'h0, dest_exp(p)}, "status");
        end
    endtask

    task automatic sample(input int n);
        pc = '{0, 0, 0, 0};
        sc = '{0, 0, 0, 0};
        repeat (n) begin
            @(negedge hclk);
            for (int c = 0; c < 4; c++) begin
                pc[c] += int'(pwm_out[c] === 1'b1);
                sc[c] += int'(strobe_out[c] === 1'b1);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; src_cmd = 32'h0; strb_cmd = 4'h0;
        inv_v = 18'h00000;
        force_v = 18'h00000;
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        check({24'h0, od_out_oe, pwm_out}, 32'h000000F0, "reset pins");
        check({27'h0, strobe_out, serial_txd}, 32'h00000000, "reset lines");
        @(posedge hclk);
        hresetn <= 1'b1;
        // routing of every destination
        for (int d = 0; d < 18; d++) begin
            sel_v[d] = 5'((d * 7 + 3) % 32);
            wr(iosw_pkg::A_SEL_BASE + 12'(4 * d), {27'h0, sel_v[d]});
        end
        run_patterns();
        $display("test routing done");
        // inversion and force-high
        inv_v = 18'h2A5A5;
        force_v = 18'h0F0CF;
        wr(iosw_pkg::A_INV, {14'h0, inv_v});
        wr(iosw_pkg::A_FORCE, {14'h0, force_v});
        run_patterns();
        // debug holds the serial transmit line high
        @(posedge hclk);
        src_cmd <= 32'h00000000;
        wr(iosw_pkg::A_CTRL, 32'h00000001);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check({31'h0, serial_txd}, 32'h00000001, "debug txd");
        $display("test invert force done");
        // pwm at two sequence indices
        wr(iosw_pkg::A_PER_BASE + 12'h008, 32'd10);
        wr(iosw_pkg::A_PER_BASE + 12'h00C, 32'd8);
        wr(iosw_pkg::A_DUTY_BASE + 12'h008, 32'h32641E00);
        wr(iosw_pkg::A_DUTY_BASE + 12'h00C, 32'h32641900);
        wr(iosw_pkg::A_CTRL, 32'h00000020);
        repeat (30) @(posedge hclk);
        sample(120);
        foreach (pc[c]) check(32'(pc[c]), 32'(c == 0 ? 0 : c == 1 ? 36 : c == 2 ? 120 : 60), "pwm a");
        wr(iosw_pkg::A_CTRL, 32'h00000030);
        repeat (30) @(posedge hclk);
        sample(120);
        foreach (pc[c]) check(32'(pc[c]), 32'(c == 0 ? 0 : c == 1 ? 30 : c == 2 ? 120 : 60), "pwm b");
        $display("test pwm done");
        // strobe lengths in clock cycles, channel 3 disabled
        for (int s = 0; s < 4; s++) wr(iosw_pkg::A_STB_LEN + 12'(4 * s), 32'(5 + s));
        wr(iosw_pkg::A_STB_EN, 32'h00000007);
        @(posedge hclk);
        strb_cmd <= 4'hF;
        sample(40);
        foreach (sc[c]) check(32'(sc[c]), 32'(c == 3 ? 0 : 5 + c), "strobe");
        @(posedge hclk);
        strb_cmd <= 4'h0;
        $display("test strobe done");
        // unmapped address reads zero and ignores writes
        wr(12'hFFC, 32'hFFFFFFFF);
        bus(1'b0, 32'h00000FFC, 32'h0, rd);
        check(rd, 32'h00000000, "unmapped");
        $display("test unmapped done");
        complete_run();
    end
endmodule // io_switch_matrix_pwm_strobe_tb_top
`default_nettype wire
